// *** hdl/csi_pkg.sv ***
// Package: constants and types of the processor state and interrupt entry block
package csi_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 13;
  localparam int SPLO_W = 6;
  localparam int BUS_AW = 4;
  localparam int BUS_DW = 16;

  // ----------------------------------------
  // Register port offsets
  // ----------------------------------------
  localparam logic [3:0] OFF_ACCUMULATOR = 4'h0;
  localparam logic [3:0] OFF_INDEX_REGISTER = 4'h1;
  localparam logic [3:0] OFF_CONDITION_FLAGS = 4'h2;
  localparam logic [3:0] OFF_STACK_POINTER = 4'h3;
  localparam logic [3:0] OFF_PROGRAM_COUNTER = 4'h4;
  localparam logic [3:0] OFF_IRQ_CONTROL = 4'h5;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h6;

  // ----------------------------------------
  // Condition flag layout: H I N Z C
  // ----------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;

  // Control and status layout
  localparam int CTL_EXT_EN = 0;
  localparam int STS_BUSY = 0;
  localparam int STS_EXT_PEND = 1;
  localparam int STS_TMR_PEND = 2;

  // ----------------------------------------
  // Reset values and stack window
  // ----------------------------------------
  localparam logic [6:0] STACK_HI = 7'h03;
  localparam logic [5:0] SP_RESET = 6'h3F;
  localparam logic [7:0] RESET_ZERO8 = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic EXT_EN_RESET = 1'b1;

  // ----------------------------------------
  // Vectors, high byte at the lower address
  // ----------------------------------------
  localparam logic [12:0] VEC_RESET = 13'h1FFE;
  localparam logic [12:0] VEC_SOFTWARE = 13'h1FFC;
  localparam logic [12:0] VEC_EXTERNAL = 13'h1FFA;
  localparam logic [12:0] VEC_TIMER = 13'h1FF8;

  // ----------------------------------------
  // Sequence lengths
  // ----------------------------------------
  localparam logic [2:0] PUSH_CALL = 3'h2;
  localparam logic [2:0] PUSH_INT = 3'h5;
  localparam logic [2:0] PULL_INT = 3'h5;
  localparam logic [2:0] VEC_LAST = 3'h3;
  localparam logic [2:0] PULL_LAST = 3'h6;
  localparam logic [2:0] PIPE_LAT = 3'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_LDA, OP_LDX, OP_SHL,
    OP_BIT_BRANCH, OP_RESET_STACK, OP_CALL, OP_SOFTWARE_TRAP, OP_RETURN_FROM_INTERRUPT
  } csi_op_type;

  typedef struct packed {
    logic valid;
    csi_op_type op;
    logic [7:0] operand;
    logic [12:0] target;
  } csi_exec_type;

  typedef struct packed {
    logic [2:0] flags;
    logic [2:0] enables;
  } csi_timer_type;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } csi_mem_type;

endpackage

// *** hdl/csi_core.sv ***
// Processor state registers, stack and interrupt entry sequencer
`timescale 1ns/100ps

// Overview of operation
// RL1: Eight-bit accumulator holds operands and results
// RL2: Eight-bit index register, also temporary storage
// RL3: Five flags: H, I, N, Z, C
// RL4: Half carry from bit 3 on adds
// RL5: Mask flag holds hardware requests pending
// RL6: Negative flag follows result sign bit
// RL7: Zero flag set when result is zero
// RL8: Carry from ALU, bit tests, shifts
// RL9: Reset and stack reset load top address
// RL10: Decrement after push, increment before pull
// RL11: Stack address fixed upper seven bits
// RL12: Stack wraps inside 64 bytes silently
// RL13: Call pushes two, interrupt five bytes
// RL14: Thirteen-bit program counter, 8K space
// RL15: Interrupt stacks registers then sets mask
// RL16: Return pulls registers and resumes
// RL17: Requests wait for instruction completion
// RL18: Enter only if pending, enabled, unmasked
// RL19: External request beats timer request
// RL20: Software trap ignores the mask flag
// RL21: Reset, software, external vector pairs
// RL22: All timer flags share one vector
// RL23: Timer request is flag and enable
// RL24: External latch cleared on service entry
// RL25: Vector high byte first, then low
module csi_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [csi_pkg::BUS_AW-1:0] reg_addr,
  input wire logic [csi_pkg::BUS_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [csi_pkg::BUS_DW-1:0] reg_rdata_q,
  // Execution side
  input wire csi_pkg::csi_exec_type exec_cmd,
  input wire logic instr_done,
  input wire logic pc_advance,
  output logic busy_q,
  output logic [12:0] program_counter_q,
  // Interrupt sources
  input wire logic ext_irq_event,
  input wire csi_pkg::csi_timer_type timer_in,
  // Memory side
  output csi_pkg::csi_mem_type mem_q,
  input wire logic [7:0] mem_rdata
);

  typedef enum {ST_IDLE, ST_PUSH, ST_VEC, ST_PULL} csi_state_type;

  // Sequencer state
  csi_state_type state_q;
  logic [2:0] cnt_q;
  logic [2:0] push_len_q;
  logic vec_after_q;
  logic [12:0] vec_q;
  logic [12:0] call_target_q;
  // Programmer-visible registers and the vector high byte
  logic [5:0] sp_q;
  logic [7:0] acc_q;
  logic [7:0] idx_q;
  logic [4:0] flags_q;
  logic ext_en_q;
  logic ext_pend_q;
  logic [7:0] vec_hi_q;

  // Combinational helpers
  logic timer_req;
  logic ext_go;
  logic tmr_go;
  logic idle;
  logic op_ok;
  logic ext_clear;
  logic pull_cap;
  logic [2:0] pull_sel;
  logic [7:0] push_byte;
  logic [12:0] stack_addr;
  logic [12:0] stack_addr_up;
  logic [8:0] sum;
  logic [4:0] half;
  logic cin;

  // ----------------------------------------
  // Request qualification
  // ----------------------------------------
  assign idle = (state_q == ST_IDLE);
  // A command meeting a taken hardware request is dropped, not half run
  assign op_ok = idle && exec_cmd.valid && !ext_go && !tmr_go;
  // Any enabled timer flag asks; all of them share one vector
  assign timer_req = |(timer_in.flags & timer_in.enables); // [RL23] [RL22]
  // Sampled only at a boundary, so a request never cuts an instruction short
  assign ext_go = idle && instr_done && ext_pend_q && ext_en_q
                  && !flags_q[csi_pkg::FLAG_I]; // [RL17] [RL18] [RL5]
  assign tmr_go = idle && instr_done && timer_req && !ext_go
                  && !flags_q[csi_pkg::FLAG_I]; // [RL19] [RL18] [RL5]
  assign ext_clear = ext_go; // [RL24]

  // ----------------------------------------
  // Stack addressing and pull alignment
  // ----------------------------------------
  // Only six bits count, so the window wraps with no error
  assign stack_addr = {csi_pkg::STACK_HI, sp_q}; // [RL11]
  assign stack_addr_up = {csi_pkg::STACK_HI, 6'(sp_q + 6'h01)}; // [RL11]
  assign pull_cap = (state_q == ST_PULL) && (cnt_q >= csi_pkg::PIPE_LAT);
  assign pull_sel = 3'(cnt_q - csi_pkg::PIPE_LAT);

  // ----------------------------------------
  // Push byte selection
  // ----------------------------------------
  // Push order: program counter low, high, index, accumulator, flags
  // Flags go out before the mask is raised, so a return restores them
  always_comb begin
    case (cnt_q)
      3'h0: push_byte = program_counter_q[7:0];
      3'h1: push_byte = {3'h0, program_counter_q[12:8]};
      3'h2: push_byte = idx_q;
      3'h3: push_byte = acc_q;
      3'h4: push_byte = {3'h0, flags_q};
      default: push_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // External request latch
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_pend_q <= 1'b0;
    end else if (ext_irq_event) begin
      // Set wins, so an event in the clearing cycle is kept for later
      ext_pend_q <= 1'b1; // [RL5]
    end else if (ext_clear) begin
      ext_pend_q <= 1'b0; // [RL24]
    end
  end

  // ----------------------------------------
  // Sequencer: stack, vectors, program counter, busy
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_VEC; // Reset fetches its own vector first
      cnt_q <= 3'h0;
      push_len_q <= 3'h0;
      vec_after_q <= 1'b0;
      vec_q <= csi_pkg::VEC_RESET; // [RL21]
      call_target_q <= csi_pkg::PC_RESET;
      sp_q <= csi_pkg::SP_RESET; // [RL9]
      program_counter_q <= csi_pkg::PC_RESET;
      vec_hi_q <= csi_pkg::RESET_ZERO8;
      mem_q <= '0;
      busy_q <= 1'b1;
    end else begin
      mem_q.we <= 1'b0;
      mem_q.re <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // Hardware entry first, then commands, then the counter and writes
          busy_q <= 1'b0;
          cnt_q <= 3'h0;
          if (ext_go || tmr_go) begin
            state_q <= ST_PUSH;
            push_len_q <= csi_pkg::PUSH_INT; // [RL13]
            vec_after_q <= 1'b1;
            vec_q <= ext_go ? csi_pkg::VEC_EXTERNAL : csi_pkg::VEC_TIMER; // [RL19] [RL22]
            busy_q <= 1'b1;
          end else if (op_ok && exec_cmd.op == csi_pkg::OP_SOFTWARE_TRAP) begin
            state_q <= ST_PUSH; // [RL20]
            push_len_q <= csi_pkg::PUSH_INT;
            vec_after_q <= 1'b1;
            vec_q <= csi_pkg::VEC_SOFTWARE; // [RL21]
            busy_q <= 1'b1;
          end else if (op_ok && exec_cmd.op == csi_pkg::OP_CALL) begin
            state_q <= ST_PUSH;
            push_len_q <= csi_pkg::PUSH_CALL; // [RL13]
            vec_after_q <= 1'b0;
            call_target_q <= exec_cmd.target;
            busy_q <= 1'b1;
          end else if (op_ok && exec_cmd.op == csi_pkg::OP_RETURN_FROM_INTERRUPT) begin
            state_q <= ST_PULL;
            busy_q <= 1'b1;
          end else if (op_ok && exec_cmd.op == csi_pkg::OP_RESET_STACK) begin
            sp_q <= csi_pkg::SP_RESET; // [RL9]
          end else if (pc_advance) begin
            program_counter_q <= 13'(program_counter_q + 13'h0001); // [RL14]
          end else if (reg_wr && reg_addr == csi_pkg::OFF_STACK_POINTER) begin
            sp_q <= reg_wdata[5:0];
          end else if (reg_wr && reg_addr == csi_pkg::OFF_PROGRAM_COUNTER) begin
            program_counter_q <= reg_wdata[12:0];
          end
        end
        ST_PUSH: begin
          // One byte a cycle, stack pointer moving down
          mem_q.we <= 1'b1;
          mem_q.addr <= stack_addr;
          mem_q.wdata <= push_byte;
          sp_q <= 6'(sp_q - 6'h01); // [RL10] [RL12]
          cnt_q <= 3'(cnt_q + 3'h1);
          if (cnt_q == 3'(push_len_q - 3'h1)) begin
            cnt_q <= 3'h0;
            if (vec_after_q) begin
              state_q <= ST_VEC; // [RL15]
            end else begin
              // Busy stays up one more cycle to cover the last stack write
              program_counter_q <= call_target_q;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_VEC: begin
          // Memory answers two edges after a read request is launched
          cnt_q <= 3'(cnt_q + 3'h1);
          case (cnt_q)
            3'h0: begin
              mem_q.re <= 1'b1;
              mem_q.addr <= vec_q; // [RL25]
            end
            3'h1: begin
              mem_q.re <= 1'b1;
              mem_q.addr <= 13'(vec_q + 13'h0001);
            end
            3'h2: vec_hi_q <= mem_rdata; // [RL25]
            default: begin
              // High byte came from the lower vector address
              program_counter_q <= 13'({vec_hi_q, mem_rdata}); // [RL25] [RL14]
              state_q <= ST_IDLE;
              busy_q <= 1'b0;
              cnt_q <= 3'h0;
            end
          endcase
        end
        ST_PULL: begin
          // Requests run ahead of the captures by the memory latency
          cnt_q <= 3'(cnt_q + 3'h1);
          if (cnt_q < csi_pkg::PULL_INT) begin
            mem_q.re <= 1'b1;
            mem_q.addr <= stack_addr_up;
            sp_q <= 6'(sp_q + 6'h01); // [RL10]
          end
          if (pull_cap && pull_sel == 3'h3) begin
            program_counter_q[12:8] <= mem_rdata[4:0]; // [RL16]
          end
          if (pull_cap && pull_sel == 3'h4) begin
            program_counter_q[7:0] <= mem_rdata; // [RL16]
          end
          if (cnt_q == csi_pkg::PULL_LAST) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            cnt_q <= 3'h0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Accumulator, index, condition flags
  // ----------------------------------------
  // Carry in only for add with carry
  assign cin = (exec_cmd.op == csi_pkg::OP_ADC) && flags_q[csi_pkg::FLAG_C];
  assign sum = 9'(acc_q) + 9'(exec_cmd.operand) + 9'(cin);
  assign half = 5'(acc_q[3:0]) + 5'(exec_cmd.operand[3:0]) + 5'(cin);

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  // Stack pulls outrank commands; commands outrank port writes
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= csi_pkg::RESET_ZERO8;
      idx_q <= csi_pkg::RESET_ZERO8;
      flags_q <= 5'h00;
      flags_q[csi_pkg::FLAG_I] <= 1'b1;
      ext_en_q <= csi_pkg::EXT_EN_RESET;
    end else begin
      // Enable writes are never lost to a running sequence
      if (reg_wr && reg_addr == csi_pkg::OFF_IRQ_CONTROL) begin
        ext_en_q <= reg_wdata[csi_pkg::CTL_EXT_EN];
      end
      if (state_q == ST_PUSH && vec_after_q && cnt_q == 3'(push_len_q - 3'h1)) begin
        flags_q[csi_pkg::FLAG_I] <= 1'b1; // [RL15]
      end else if (pull_cap) begin
        case (pull_sel)
          3'h0: flags_q <= mem_rdata[4:0]; // [RL16]
          3'h1: acc_q <= mem_rdata;
          3'h2: idx_q <= mem_rdata;
          default: ;
        endcase
      end else if (op_ok) begin
        case (exec_cmd.op)
          csi_pkg::OP_ADD, csi_pkg::OP_ADC: begin
            acc_q <= sum[7:0]; // [RL1]
            flags_q[csi_pkg::FLAG_H] <= half[4]; // [RL4]
            flags_q[csi_pkg::FLAG_C] <= sum[8]; // [RL8]
            flags_q[csi_pkg::FLAG_N] <= sum[7]; // [RL6]
            flags_q[csi_pkg::FLAG_Z] <= (sum[7:0] == 8'h00); // [RL7]
          end
          csi_pkg::OP_SUB: begin
            // Carry holds the borrow
            acc_q <= 8'(acc_q - exec_cmd.operand);
            flags_q[csi_pkg::FLAG_C] <= (acc_q < exec_cmd.operand); // [RL8]
            flags_q[csi_pkg::FLAG_N] <= 1'(8'(acc_q - exec_cmd.operand) >> 7); // [RL6]
            flags_q[csi_pkg::FLAG_Z] <= (acc_q == exec_cmd.operand); // [RL7]
          end
          csi_pkg::OP_AND: begin
            acc_q <= acc_q & exec_cmd.operand;
            flags_q[csi_pkg::FLAG_N] <= acc_q[7] & exec_cmd.operand[7]; // [RL6]
            flags_q[csi_pkg::FLAG_Z] <= ((acc_q & exec_cmd.operand) == 8'h00); // [RL7]
          end
          csi_pkg::OP_LDA: begin
            acc_q <= exec_cmd.operand; // [RL1]
            flags_q[csi_pkg::FLAG_N] <= exec_cmd.operand[7];
            flags_q[csi_pkg::FLAG_Z] <= (exec_cmd.operand == 8'h00);
          end
          csi_pkg::OP_LDX: begin
            idx_q <= exec_cmd.operand; // [RL2]
            flags_q[csi_pkg::FLAG_N] <= exec_cmd.operand[7];
            flags_q[csi_pkg::FLAG_Z] <= (exec_cmd.operand == 8'h00);
          end
          csi_pkg::OP_SHL: begin
            // The bit shifted out lands in carry
            acc_q <= {acc_q[6:0], 1'b0};
            flags_q[csi_pkg::FLAG_C] <= acc_q[7]; // [RL8]
            flags_q[csi_pkg::FLAG_N] <= acc_q[6];
            flags_q[csi_pkg::FLAG_Z] <= (acc_q[6:0] == 7'h00);
          end
          csi_pkg::OP_BIT_BRANCH: flags_q[csi_pkg::FLAG_C] <= exec_cmd.operand[0]; // [RL8]
          default: ;
        endcase
      end else if (idle && reg_wr) begin
        case (reg_addr)
          csi_pkg::OFF_ACCUMULATOR: acc_q <= reg_wdata[7:0]; // [RL1]
          csi_pkg::OFF_INDEX_REGISTER: idx_q <= reg_wdata[7:0]; // [RL2]
          csi_pkg::OFF_CONDITION_FLAGS: flags_q <= reg_wdata[4:0]; // [RL3]
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Register read port, data one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        csi_pkg::OFF_ACCUMULATOR: reg_rdata_q <= {8'h00, acc_q};
        csi_pkg::OFF_INDEX_REGISTER: reg_rdata_q <= {8'h00, idx_q};
        csi_pkg::OFF_CONDITION_FLAGS: reg_rdata_q <= {11'h000, flags_q}; // [RL3]
        // The stack pointer reads as its full memory address
        csi_pkg::OFF_STACK_POINTER: reg_rdata_q <= {3'h0, stack_addr}; // [RL11]
        csi_pkg::OFF_PROGRAM_COUNTER: reg_rdata_q <= {3'h0, program_counter_q};
        csi_pkg::OFF_IRQ_CONTROL: reg_rdata_q <= {15'h0000, ext_en_q};
        csi_pkg::OFF_IRQ_STATUS: reg_rdata_q <= {13'h0000, timer_req, ext_pend_q, busy_q};
        default: reg_rdata_q <= 16'h0000;
      endcase
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

endmodule

// *** tb/csi_core_chk.sv ***
// Port checker for the state and interrupt entry block
`timescale 1ns/100ps
module csi_core_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Observed ports
  input wire logic reg_rd,
  input wire logic [csi_pkg::BUS_DW-1:0] reg_rdata_q,
  input wire csi_pkg::csi_exec_type exec_cmd,
  input wire logic instr_done,
  input wire logic pc_advance,
  input wire logic busy_q,
  input wire logic [12:0] program_counter_q,
  input wire csi_pkg::csi_mem_type mem_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
    else $error("read data outside its answer cycle");
  chk_stack_window: assert property (mem_q.we |-> mem_q.addr[12:6] == 7'h03)
    else $error("push outside the stack window");
  chk_push_down: assert property (mem_q.we && $past(mem_q.we) |->
    mem_q.addr[5:0] == $past(mem_q.addr[5:0]) - 6'h01)
    else $error("push address did not step down");
  chk_push_pair: assert property ($rose(mem_q.we) |-> ##1 mem_q.we)
    else $error("single byte push");
  chk_entry_five: assert property ($rose(mem_q.we) ##1 mem_q.we[*2] |=>
    mem_q.we ##1 mem_q.we ##1 (!mem_q.we && mem_q.re))
    else $error("entry did not push five bytes then fetch");
  chk_vec_pair: assert property (mem_q.re && mem_q.addr[12:3] == 10'h3FF && !mem_q.addr[0]
    |=> mem_q.re && mem_q.addr == $past(mem_q.addr) + 13'h0001)
    else $error("vector low byte not read next");
  chk_reset_vec: assert property ($fell(rst) |-> ##[0:2] (mem_q.re && mem_q.addr == 13'h1FFE))
    else $error("reset vector not fetched");
  chk_boot_busy: assert property ($fell(rst) |-> busy_q[*2] ##[1:8] !busy_q)
    else $error("reset sequence length wrong");
  chk_mem_busy: assert property (mem_q.we || mem_q.re |-> busy_q)
    else $error("memory access while idle");
  chk_pc_step: assert property (!busy_q && pc_advance && !exec_cmd.valid && !instr_done
    |=> program_counter_q == $past(program_counter_q) + 13'h0001)
    else $error("program counter did not step");
endmodule

bind csi_core csi_core_chk u_chk (.clk(clk), .rst(rst), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .exec_cmd(exec_cmd), .instr_done(instr_done),
  .pc_advance(pc_advance), .busy_q(busy_q), .program_counter_q(program_counter_q),
  .mem_q(mem_q));

// *** tb/csi_mem_model.sv ***
// Memory model answering stack and vector accesses
`timescale 1ns/100ps
module csi_mem_model (
  // Clock
  input wire logic clk,
  // Request and answer
  input wire csi_pkg::csi_mem_type mem_q,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:8191];

  initial begin
    for (int i = 0; i < 8192; i++) begin
      ram[i] = 8'h00;
    end
    ram[13'h1FFE] = 8'h01;
    ram[13'h1FFC] = 8'h02;
    ram[13'h1FFD] = 8'h34;
    ram[13'h1FFA] = 8'h03;
    ram[13'h1FFB] = 8'h56;
    ram[13'h1FF8] = 8'h04;
    ram[13'h1FF9] = 8'h78;
    mem_rdata = 8'hA5;
  end

  always @(posedge clk) begin
    if (mem_q.we) begin
      ram[mem_q.addr] <= mem_q.wdata;
    end
    // Outside an answer cycle the data keeps changing, so a late capture is caught
    mem_rdata <= mem_q.re ? ram[mem_q.addr] : ~mem_rdata;
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the state and interrupt entry block
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata_q;
  csi_pkg::csi_exec_type exec_cmd = '0;
  logic instr_done = 1'b0;
  logic pc_advance = 1'b0;
  logic busy_q;
  logic [12:0] program_counter_q;
  logic ext_irq_event = 1'b0;
  csi_pkg::csi_timer_type timer_in = '0;
  csi_pkg::csi_mem_type mem_q;
  logic [7:0] mem_rdata;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 36;
  int a, b, cin, r, f;
  csi_pkg::csi_op_type alu_ops [5] = '{csi_pkg::OP_SUB, csi_pkg::OP_AND, csi_pkg::OP_LDA,
    csi_pkg::OP_LDX, csi_pkg::OP_SHL};

  always #5 clk = ~clk;

  csi_core uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .exec_cmd(exec_cmd),
    .instr_done(instr_done), .pc_advance(pc_advance), .busy_q(busy_q),
    .program_counter_q(program_counter_q), .ext_irq_event(ext_irq_event),
    .timer_in(timer_in), .mem_q(mem_q), .mem_rdata(mem_rdata));
  csi_mem_model u_mem (.clk(clk), .mem_q(mem_q), .mem_rdata(mem_rdata));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (busy_q !== 1'b0 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp({15'h0000, busy_q}, 16'h0000);
  endtask

  // Offsets: 0 acc, 1 idx, 2 flags, 3 stack, 4 pc, 5 control, 6 status
  task automatic rd(input logic [3:0] off, input logic [15:0] exp, input logic [15:0] msk);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= off;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata_q & msk, exp & msk);
  endtask

  task automatic wr(input logic [3:0] off, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= off;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic exe(input csi_pkg::csi_op_type op, input logic [7:0] opd,
                     input logic [12:0] tg);
    @(posedge clk);
    exec_cmd <= {1'b1, op, opd, tg};
    @(posedge clk);
    exec_cmd.valid <= 1'b0;
    wait_idle();
  endtask

  task automatic boundary(input logic ext);
    @(posedge clk);
    ext_irq_event <= ext;
    @(posedge clk);
    ext_irq_event <= 1'b0;
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    wait_idle();
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_idle();
    rd(4'h3, 16'h00FF, 16'hFFFF);
    rd(4'h2, 16'h0008, 16'hFFFF);
    rd(4'h4, 16'h0100, 16'hFFFF);
    rd(4'h5, 16'h0001, 16'hFFFF);
    rd(4'h9, 16'h0000, 16'hFFFF);
    a = $random(seed) & 255;
    wr(4'h1, 16'(a));
    rd(4'h1, 16'(a), 16'hFFFF);
    for (int k = 0; k < 8; k++) begin
      a = $random(seed) & 255;
      b = $random(seed) & 255;
      cin = $random(seed) & 1;
      wr(4'h0, 16'(a));
      wr(4'h2, 16'(cin));
      exe((k % 2) ? csi_pkg::OP_ADC : csi_pkg::OP_ADD, 8'(b), 13'h0000);
      if (k % 2 == 0) begin
        cin = 0;
      end
      r = a + b + cin;
      f = ((((a & 15) + (b & 15) + cin) > 15) ? 16 : 0) + ((r & 128) ? 4 : 0);
      f = f + (((r & 255) == 0) ? 2 : 0) + ((r > 255) ? 1 : 0);
      rd(4'h0, 16'(r & 255), 16'hFFFF);
      rd(4'h2, 16'(f), 16'hFFFF);
    end
    // Subtract, and, loads and shift against the bench model
    for (int k = 0; k < 5; k++) begin
      a = $random(seed) & 255;
      b = $random(seed) & 255;
      wr(4'h0, 16'(a));
      wr(4'h2, 16'h0000);
      exe(alu_ops[k], 8'(b), 13'h0000);
      r = (k == 0) ? ((a - b) & 255) : (k == 1) ? (a & b) : (k == 4) ? ((a * 2) & 255) : b;
      f = (k == 0 && a < b) || (k == 4 && a > 127) ? 1 : 0;
      f = f + ((r & 128) ? 4 : 0) + ((r == 0) ? 2 : 0);
      rd(4'h0, 16'((k == 3) ? a : r), 16'hFFFF);
      rd(4'h2, 16'(f), 16'hFFFF);
      if (k == 3) begin
        rd(4'h1, 16'(b), 16'hFFFF);
      end
    end
    exe(csi_pkg::OP_BIT_BRANCH, 8'h01, 13'h0000);
    rd(4'h2, 16'h0001, 16'h0001);
    wr(4'h2, 16'h0000);
    wr(4'h4, 16'h0123);
    exe(csi_pkg::OP_SOFTWARE_TRAP, 8'h00, 13'h0000);
    rd(4'h4, 16'h0234, 16'hFFFF);
    rd(4'h2, 16'h0008, 16'h0008);
    rd(4'h3, 16'h00FA, 16'hFFFF);
    exe(csi_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 13'h0000);
    rd(4'h4, 16'h0123, 16'hFFFF);
    rd(4'h2, 16'h0000, 16'hFFFF);
    rd(4'h3, 16'h00FF, 16'hFFFF);
    // Both sources raised while masked
    wr(4'h2, 16'h0008);
    timer_in <= 6'h24;
    boundary(1'b1);
    rd(4'h6, 16'h0006, 16'hFFFF);
    rd(4'h4, 16'h0123, 16'hFFFF);
    wr(4'h2, 16'h0000);
    boundary(1'b0);
    rd(4'h4, 16'h0356, 16'hFFFF);
    rd(4'h6, 16'h0004, 16'hFFFF);
    exe(csi_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 13'h0000);
    boundary(1'b0);
    rd(4'h4, 16'h0478, 16'hFFFF);
    exe(csi_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 13'h0000);
    timer_in.enables <= 3'b000;
    wr(4'h5, 16'h0000);
    boundary(1'b1);
    rd(4'h4, 16'h0123, 16'hFFFF);
    wr(4'h5, 16'h0001);
    boundary(1'b0);
    rd(4'h4, 16'h0356, 16'hFFFF);
    exe(csi_pkg::OP_CALL, 8'h00, 13'h0ABC);
    rd(4'h4, 16'h0ABC, 16'hFFFF);
    rd(4'h3, 16'h00F8, 16'hFFFF);
    exe(csi_pkg::OP_RESET_STACK, 8'h00, 13'h0000);
    rd(4'h3, 16'h00FF, 16'hFFFF);
    // Trap with the mask set, pushing across the bottom of the window
    wr(4'h2, 16'h0008);
    wr(4'h3, 16'h00C1);
    exe(csi_pkg::OP_SOFTWARE_TRAP, 8'h00, 13'h0000);
    rd(4'h3, 16'h00FC, 16'hFFFF);
    rd(4'h4, 16'h0234, 16'hFFFF);
    @(posedge clk);
    pc_advance <= 1'b1;
    @(posedge clk);
    pc_advance <= 1'b0;
    rd(4'h4, 16'h0235, 16'hFFFF);
    final_report();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
endmodule
